// ==== hdl/dlms_ctrl.sv ====
// role, multiplier, sleep and error-flag control of a display serial link end
// Operation
// - role strap high makes the device link master, low makes it slave.
// - multiplier code 00/01/10 selects 8X/10X/12X; 11 is reserved.
// - only a master enables its PLL, which makes the serial clock.
// - serial clock equals reference clock times the selected factor.
// - one bit per serial clock edge: bit rate is twice serial clock.
// - sleeping slave: data low, selects and strobes high; error low on both.
// - slave powers up with all outputs driven at their idle levels.
// - master powers up driving its error flag low.
// - master sleeps whenever sleep request is driven low.
// - awake master sleeps when the reference clock stops at a static level.
// - sleeping master releases its host inputs to high impedance.
// - slave with sleep request high follows link state to wake or sleep.
// - slave sleeps on its own sleep request and idles its outputs.
// - store-only slave performs writes only, never reads or turnarounds.
// - master error flag reports a CRC error on returned read data.
// - slave error flag reports any CRC error on received frames.
// - master ignores host cycles that select neither panel.
// - slave data bus is two-way; selects, strobes, command select are outputs.
// - drive straps set slave drive; low sel0 softens slave data edges, strobes stay sharp.
// - slave error stays high until the slave sleeps (sleep request or link inactive) or power cycle.
// - master holds off the link for a reference count after PLL lock.
// - slave write strobe is low for exactly twelve serial clock cycles.
`timescale 1ns/1ps
module dlms_ctrl #(
  parameter int HOLDOFF_CYC = dlms_pkg::HOLDOFF_REF_CYC,
  parameter int WR_LOW = dlms_pkg::WR_LOW_SCK,
  parameter int RD_LOW = dlms_pkg::RD_LOW_SCK,
  parameter int STOP_CYC = dlms_pkg::CLK_STOP_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic role_select,
  input wire logic factory_test_select,
  input wire logic [1:0] multiplier_select,
  input wire logic store_only_select,
  input wire logic drive_strength_sel0,
  input wire logic drive_strength_sel1,
  input wire logic sleep_request_n,
  input wire logic ref_clk,
  input wire logic pll_locked,
  input wire logic link_active,
  input wire logic serial_clk,
  input wire logic host_cs_main_n,
  input wire logic host_cs_sub_n,
  input wire logic host_wr_n,
  input wire logic host_rd_n,
  input wire logic host_cmd_data,
  input wire logic [17:0] host_data,
  input wire logic rd_crc_err,
  input wire logic rx_crc_err,
  input wire logic rx_valid,
  input wire logic rx_is_read,
  input wire dlms_pkg::dlms_word_s rx_word,
  input wire logic [17:0] panel_data_in,
  output logic is_master_q,
  output logic test_mode_q,
  output logic pll_enable_q,
  output logic [4:0] pll_factor_q,
  output logic [5:0] bits_per_ref_q,
  output logic link_ready_q,
  output logic host_in_en_q,
  output logic fwd_valid_q,
  output dlms_pkg::dlms_word_s fwd_word_q,
  output logic fwd_lost_q,
  output logic link_fault_flag_q,
  output logic turnaround_en_q,
  output logic panel_select_main_n_q,
  output logic panel_select_sub_n_q,
  output logic panel_wr_n_q,
  output logic panel_rd_n_q,
  output logic panel_cmd_data_q,
  output logic [17:0] panel_data_out_q,
  output logic panel_data_oe_q,
  output logic [17:0] rd_data_q,
  output logic rd_valid_q,
  output logic data_soft_edge_q,
  output logic strobe_soft_edge_q,
  output logic [1:0] drive_level_q
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (HOLDOFF_CYC < 1 || HOLDOFF_CYC > 65535 || WR_LOW < 1 || WR_LOW > 255 ||
      RD_LOW < 1 || RD_LOW > 255 || STOP_CYC < 2 || STOP_CYC > 65535) begin : g_param_chk
    $error("dlms_ctrl: parameter out of range");
  end

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  localparam int SW = dlms_pkg::SYNC_W;
  // pins rest at their idle levels in reset so no false strobe edge follows it
  localparam logic [SW-1:0] SYNC_IDLE = {12'h000, 4'hF, 37'h0};
  logic [SW-1:0] async_in;
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  logic ref_d_q, sck_d_q, wr_d_q, rd_d_q;
  logic role_s, test_s, store_only_s, ds0_s, ds1_s, sleep_n_s, ref_s, lock_s, link_s, sck_s;
  logic cs_main_s, cs_sub_s, wr_s, rd_s, cd_s;
  logic [1:0] mult_s;
  logic [17:0] hd_s;
  logic [17:0] pd_s;
  assign async_in = {role_select, factory_test_select, multiplier_select, store_only_select,
                     drive_strength_sel0, drive_strength_sel1, sleep_request_n, ref_clk,
                     pll_locked, link_active, serial_clk, host_cs_main_n, host_cs_sub_n,
                     host_wr_n, host_rd_n, host_cmd_data, host_data, panel_data_in};
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= SYNC_IDLE;
      sync_q <= SYNC_IDLE;
      ref_d_q <= 1'b0;
      sck_d_q <= 1'b0;
      wr_d_q <= 1'b1;
      rd_d_q <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      ref_d_q <= ref_s;
      sck_d_q <= sck_s;
      wr_d_q <= wr_s;
      rd_d_q <= rd_s;
    end
  end
  assign {role_s, test_s, mult_s, store_only_s, ds0_s, ds1_s, sleep_n_s, ref_s, lock_s,
          link_s, sck_s, cs_main_s, cs_sub_s, wr_s, rd_s, cd_s, hd_s, pd_s} = sync_q;

  // ****************************************************************
  // edge detectors on synchronised pins
  // ****************************************************************
  logic ref_rise, ref_edge, sck_rise, wr_fall, rd_fall, cs_any;
  assign ref_rise = ref_s & ~ref_d_q;
  assign ref_edge = ref_s ^ ref_d_q;
  assign sck_rise = sck_s & ~sck_d_q;
  assign wr_fall = wr_d_q & ~wr_s;
  assign rd_fall = rd_d_q & ~rd_s;
  assign cs_any = ~cs_main_s | ~cs_sub_s;

  // ****************************************************************
  // static configuration
  // ****************************************************************
  logic [4:0] factor_d;
  always_comb begin
    case (mult_s)
      dlms_pkg::MULT_CODE_8X: factor_d = dlms_pkg::FACTOR_8X;
      dlms_pkg::MULT_CODE_10X: factor_d = dlms_pkg::FACTOR_10X;
      dlms_pkg::MULT_CODE_12X: factor_d = dlms_pkg::FACTOR_12X;
      default: factor_d = dlms_pkg::FACTOR_NONE;
    endcase
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      is_master_q <= 1'b0;
      test_mode_q <= 1'b0;
      pll_factor_q <= dlms_pkg::FACTOR_NONE;
      bits_per_ref_q <= '0;
      turnaround_en_q <= 1'b0;
      data_soft_edge_q <= 1'b0;
      strobe_soft_edge_q <= 1'b0;
      drive_level_q <= '0;
    end else begin
      is_master_q <= role_s;
      test_mode_q <= test_s;
      pll_factor_q <= role_s ? factor_d : dlms_pkg::FACTOR_NONE;
      bits_per_ref_q <= role_s ? {factor_d, 1'b0} : 6'h00;
      turnaround_en_q <= ~role_s & ~store_only_s;
      data_soft_edge_q <= ~role_s & ~ds0_s;
      strobe_soft_edge_q <= 1'b0;
      drive_level_q <= role_s ? 2'h0 : {ds1_s, ds0_s};
    end
  end

  // ****************************************************************
  // master: reference clock stop detector
  // ****************************************************************
  logic [15:0] stop_cnt_q;
  logic clk_stop_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_cnt_q <= '0;
      clk_stop_q <= 1'b0;
    end else if (ref_edge) begin
      stop_cnt_q <= '0;
      clk_stop_q <= 1'b0;
    end else if (stop_cnt_q == 16'(STOP_CYC - 1)) begin
      clk_stop_q <= 1'b1;
    end else begin
      stop_cnt_q <= stop_cnt_q + 16'h0001;
    end
  end

  // ****************************************************************
  // master: sleep, PLL lock and hold-off sequence
  // ****************************************************************
  dlms_pkg::dlms_mst_e mst_q;
  logic [15:0] hold_cnt_q;
  logic m_sleep;
  assign m_sleep = ~role_s | ~sleep_n_s | clk_stop_q | (mult_s == dlms_pkg::MULT_CODE_RSVD);
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mst_q <= dlms_pkg::MST_SLEEP;
      hold_cnt_q <= '0;
    end else if (m_sleep) begin
      mst_q <= dlms_pkg::MST_SLEEP;
      hold_cnt_q <= '0;
    end else begin
      case (mst_q)
        dlms_pkg::MST_SLEEP: mst_q <= dlms_pkg::MST_PLL_WAIT;
        dlms_pkg::MST_PLL_WAIT: begin
          hold_cnt_q <= '0;
          if (lock_s) begin
            mst_q <= dlms_pkg::MST_HOLDOFF;
          end
        end
        dlms_pkg::MST_HOLDOFF: begin
          if (ref_rise) begin
            hold_cnt_q <= hold_cnt_q + 16'h0001;
            if (hold_cnt_q == 16'(HOLDOFF_CYC - 1)) begin
              mst_q <= dlms_pkg::MST_READY;
            end
          end
        end
        dlms_pkg::MST_READY: mst_q <= dlms_pkg::MST_READY;
        default: mst_q <= dlms_pkg::MST_SLEEP;
      endcase
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_enable_q <= 1'b0;
      host_in_en_q <= 1'b0;
      link_ready_q <= 1'b0;
    end else begin
      pll_enable_q <= ~m_sleep && mst_q != dlms_pkg::MST_SLEEP;
      host_in_en_q <= ~m_sleep && mst_q != dlms_pkg::MST_SLEEP;
      link_ready_q <= ~m_sleep && mst_q == dlms_pkg::MST_READY;
    end
  end

  // ****************************************************************
  // master: host write forwarding
  // ****************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fwd_valid_q <= 1'b0;
      fwd_lost_q <= 1'b0;
      fwd_word_q <= '0;
    end else begin
      fwd_valid_q <= 1'b0;
      fwd_lost_q <= 1'b0;
      if (role_s && ~m_sleep && wr_fall && cs_any) begin
        if (mst_q == dlms_pkg::MST_READY) begin
          fwd_valid_q <= 1'b1;
          fwd_word_q <= '{sel_sub: cs_main_s, cmd_data: cd_s, data: hd_s};
        end else begin
          fwd_lost_q <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // slave: panel bus sequencer
  // ****************************************************************
  dlms_pkg::dlms_slv_e slv_q;
  logic [7:0] strobe_cnt_q;
  logic s_sleep;
  assign s_sleep = role_s | ~sleep_n_s | ~link_s;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      slv_q <= dlms_pkg::SLV_SLEEP;
      strobe_cnt_q <= '0;
      {panel_select_main_n_q, panel_select_sub_n_q, panel_wr_n_q, panel_rd_n_q,
       panel_cmd_data_q} <= 5'h1F;
      panel_data_out_q <= '0;
      panel_data_oe_q <= 1'b1;
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end else if (s_sleep) begin
      slv_q <= dlms_pkg::SLV_SLEEP;
      strobe_cnt_q <= '0;
      {panel_select_main_n_q, panel_select_sub_n_q, panel_wr_n_q, panel_rd_n_q,
       panel_cmd_data_q} <= 5'h1F;
      panel_data_out_q <= '0;
      panel_data_oe_q <= 1'b1;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      case (slv_q)
        dlms_pkg::SLV_SLEEP: slv_q <= dlms_pkg::SLV_IDLE;
        dlms_pkg::SLV_IDLE: begin
          strobe_cnt_q <= '0;
          if (rx_valid && !rx_is_read) begin
            slv_q <= dlms_pkg::SLV_WRITE;
            panel_select_main_n_q <= rx_word.sel_sub;
            panel_select_sub_n_q <= ~rx_word.sel_sub;
            panel_cmd_data_q <= rx_word.cmd_data;
            panel_data_out_q <= rx_word.data;
            panel_wr_n_q <= 1'b0;
          end else if (rx_valid && !store_only_s) begin
            slv_q <= dlms_pkg::SLV_READ;
            panel_select_main_n_q <= rx_word.sel_sub;
            panel_select_sub_n_q <= ~rx_word.sel_sub;
            panel_cmd_data_q <= rx_word.cmd_data;
            panel_data_oe_q <= 1'b0;
            panel_rd_n_q <= 1'b0;
          end
        end
        dlms_pkg::SLV_WRITE: begin
          if (sck_rise) begin
            strobe_cnt_q <= strobe_cnt_q + 8'h01;
            if (strobe_cnt_q == 8'(WR_LOW - 1)) begin
              panel_wr_n_q <= 1'b1;
              slv_q <= dlms_pkg::SLV_IDLE;
            end
          end
        end
        dlms_pkg::SLV_READ: begin
          if (sck_rise) begin
            strobe_cnt_q <= strobe_cnt_q + 8'h01;
            if (strobe_cnt_q == 8'(RD_LOW - 1)) begin
              panel_rd_n_q <= 1'b1;
              panel_data_oe_q <= 1'b1;
              rd_data_q <= pd_s;
              rd_valid_q <= 1'b1;
              slv_q <= dlms_pkg::SLV_IDLE;
            end
          end
        end
        default: slv_q <= dlms_pkg::SLV_SLEEP;
      endcase
    end
  end

  // ****************************************************************
  // error flag, both roles
  // ****************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      link_fault_flag_q <= 1'b0;
    end else if (role_s) begin
      if (m_sleep) begin
        link_fault_flag_q <= 1'b0;
      end else if (rd_crc_err) begin
        link_fault_flag_q <= 1'b1;
      end else if (rd_fall && cs_any) begin
        link_fault_flag_q <= 1'b0;
      end
    end else begin
      if (s_sleep) begin
        link_fault_flag_q <= 1'b0;
      end else if (rx_crc_err) begin
        link_fault_flag_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sleep_err_low_a: assert property ((m_sleep && role_s) || (s_sleep && !role_s) |=>
    !link_fault_flag_q) else $error("error flag not low in sleep");
  slave_idle_pins_a: assert property (s_sleep |=> panel_data_out_q == 18'h00000 &&
    panel_wr_n_q && panel_rd_n_q && panel_select_main_n_q && panel_select_sub_n_q)
    else $error("slave pins not idle in sleep");
  pll_master_only_a: assert property (pll_enable_q |-> $past(role_s))
    else $error("pll enabled on slave");
  factor_map_a: assert property (role_s && mult_s == dlms_pkg::MULT_CODE_10X &&
    $stable(mult_s) |=> pll_factor_q == dlms_pkg::FACTOR_10X && bits_per_ref_q == 6'h14)
    else $error("factor mismatch");
  sleep_enter_a: assert property (role_s && !sleep_n_s |=> mst_q == dlms_pkg::MST_SLEEP
    ##1 !pll_enable_q && !host_in_en_q) else $error("master did not sleep");
  hiz_sleep_a: assert property (mst_q == dlms_pkg::MST_SLEEP |=> !host_in_en_q)
    else $error("host inputs enabled while asleep");
  fwd_ready_a: assert property (fwd_valid_q |-> $past(mst_q == dlms_pkg::MST_READY &&
    cs_any)) else $error("forward before ready or without select");
  holdoff_full_a: assert property (mst_q == dlms_pkg::MST_HOLDOFF ##1
    mst_q == dlms_pkg::MST_READY |-> $past(hold_cnt_q) == 16'(HOLDOFF_CYC - 1))
    else $error("hold-off cut short");
  wr_width_a: assert property ($rose(panel_wr_n_q) && !s_sleep && $past(!s_sleep) |->
    $past(strobe_cnt_q) == 8'(WR_LOW - 1)) else $error("write strobe width wrong");
  store_only_a: assert property (store_only_s && slv_q == dlms_pkg::SLV_IDLE |=>
    slv_q != dlms_pkg::SLV_READ) else $error("read in store-only mode");
  err_sticky_a: assert property (!role_s && link_fault_flag_q && !s_sleep ##1 !s_sleep
    |-> link_fault_flag_q) else $error("slave error flag dropped");

  ready_cov_c: cover property (mst_q == dlms_pkg::MST_HOLDOFF ##1 mst_q == dlms_pkg::MST_READY);
  slave_write_c: cover property ($fell(panel_wr_n_q) ##[1:300] $rose(panel_wr_n_q));
  stop_sleep_c: cover property (role_s && sleep_n_s && $rose(clk_stop_q));
  slave_read_c: cover property (rd_valid_q);

endmodule : dlms_ctrl

// ==== hdl/dlms_pkg.sv ====
// shared constants and carriers for the display link mode and sleep controller
package dlms_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_STOP_NS = 1000;
  localparam int CLK_STOP_CYC = (CLK_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLDOFF_REF_CYC = 1024;
  localparam int WR_LOW_SCK = 12;
  localparam int RD_LOW_SCK = 62;
  localparam int SYNC_W = 53;

  // ****************************************************************
  // multiplier straps and factors
  // ****************************************************************
  localparam logic [1:0] MULT_CODE_8X = 2'h0;
  localparam logic [1:0] MULT_CODE_10X = 2'h1;
  localparam logic [1:0] MULT_CODE_12X = 2'h2;
  localparam logic [1:0] MULT_CODE_RSVD = 2'h3;
  localparam logic [4:0] FACTOR_8X = 5'h08;
  localparam logic [4:0] FACTOR_10X = 5'h0A;
  localparam logic [4:0] FACTOR_12X = 5'h0C;
  localparam logic [4:0] FACTOR_NONE = 5'h00;

  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic [1:0] {
    MST_SLEEP = 2'h0,
    MST_PLL_WAIT = 2'h1,
    MST_HOLDOFF = 2'h3,
    MST_READY = 2'h2
  } dlms_mst_e;

  typedef enum logic [1:0] {
    SLV_SLEEP = 2'h0,
    SLV_IDLE = 2'h1,
    SLV_WRITE = 2'h3,
    SLV_READ = 2'h2
  } dlms_slv_e;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic sel_sub;
    logic cmd_data;
    logic [17:0] data;
  } dlms_word_s;

endpackage : dlms_pkg

// ==== verif/dlms_link_model.sv ====
// companion link end model: hands frames to the slave with a gated serial clock
`timescale 1ns/1ps
module dlms_link_model (
  input wire logic mclk,
  input wire logic send,
  input wire logic rd,
  input wire logic bad,
  input wire dlms_pkg::dlms_word_s win,
  output logic rx_valid,
  output logic rx_is_read,
  output dlms_pkg::dlms_word_s rx_word,
  output logic rx_crc_err,
  output logic serial_clk
);
  initial serial_clk = 1'b0;
  // outside a frame the frame lines carry the inverse of the last frame
  always @(posedge mclk) begin
    rx_valid <= send;
    rx_is_read <= send ? rd : ~rd;
    rx_word <= send ? win : ~win;
    rx_crc_err <= send & bad;
  end
  // serial clock runs sixteen cycles after each frame and rests low between frames
  always @(posedge rx_valid) begin
    #83;
    repeat (16) begin
      serial_clk = 1'b1;
      #80;
      serial_clk = 1'b0;
      #80;
    end
  end
endmodule : dlms_link_model

// ==== verif/testbench.sv ====
// self-checking bench: master sequencing, host forwarding, slave strobes, error flag
`timescale 1ns/1ps
module testbench;
  // ****************************************************************
  // stimulus and observation
  // ****************************************************************
  localparam int HOLD = 8;
  localparam int WRL = 12;
  localparam int RDL = 4;
  logic mclk = 1'b0, sys_rst = 1'b1, role_select = 1'b1, factory_test_select = 1'b0;
  logic store_only_select = 1'b0, drive_strength_sel0 = 1'b1, drive_strength_sel1 = 1'b1;
  logic sleep_request_n = 1'b1, ref_clk = 1'b0, pll_locked = 1'b0, link_active = 1'b1;
  logic host_cs_main_n = 1'b1, host_cs_sub_n = 1'b1, host_wr_n = 1'b1, host_rd_n = 1'b1;
  logic host_cmd_data = 1'b0, rd_crc_err = 1'b0, send = 1'b0, rd = 1'b0, bad = 1'b0;
  logic ref_run = 1'b1;
  logic [1:0] multiplier_select = 2'h0;
  logic [17:0] host_data = 18'h00000, panel_data_in = 18'h00000;
  dlms_pkg::dlms_word_s win = '0;
  logic rx_valid, rx_is_read, rx_crc_err, serial_clk, is_master_q, test_mode_q;
  logic pll_enable_q, link_ready_q, host_in_en_q, fwd_valid_q, fwd_lost_q;
  logic link_fault_flag_q, turnaround_en_q, panel_select_main_n_q, panel_select_sub_n_q;
  logic panel_wr_n_q, panel_rd_n_q, panel_cmd_data_q, panel_data_oe_q, rd_valid_q;
  logic data_soft_edge_q, strobe_soft_edge_q;
  logic [4:0] pll_factor_q;
  logic [5:0] bits_per_ref_q;
  logic [1:0] drive_level_q;
  logic [17:0] panel_data_out_q, rd_data_q;
  logic [19:0] w;
  dlms_pkg::dlms_word_s rx_word, fwd_word_q;
  int n_fail = 0, cmp_count = 0, n_sck = 0, n_lost = 0, n_rdv = 0, ref_div = 0, i, k;
  logic [19:0] exp_q[$];
  wire [22:0] idle_w = {panel_select_main_n_q, panel_select_sub_n_q, panel_wr_n_q,
    panel_rd_n_q, panel_cmd_data_q, panel_data_out_q};

  dlms_ctrl #(.HOLDOFF_CYC(HOLD), .WR_LOW(WRL), .RD_LOW(RDL), .STOP_CYC(100)) dut_u (
    .mclk, .sys_rst, .role_select, .factory_test_select, .multiplier_select,
    .store_only_select, .drive_strength_sel0, .drive_strength_sel1, .sleep_request_n,
    .ref_clk, .pll_locked, .link_active, .serial_clk, .host_cs_main_n, .host_cs_sub_n,
    .host_wr_n, .host_rd_n, .host_cmd_data, .host_data, .rd_crc_err, .rx_crc_err,
    .rx_valid, .rx_is_read, .rx_word, .panel_data_in, .is_master_q, .test_mode_q,
    .pll_enable_q, .pll_factor_q, .bits_per_ref_q, .link_ready_q, .host_in_en_q,
    .fwd_valid_q, .fwd_word_q, .fwd_lost_q, .link_fault_flag_q, .turnaround_en_q,
    .panel_select_main_n_q, .panel_select_sub_n_q, .panel_wr_n_q, .panel_rd_n_q,
    .panel_cmd_data_q, .panel_data_out_q, .panel_data_oe_q, .rd_data_q, .rd_valid_q,
    .data_soft_edge_q, .strobe_soft_edge_q, .drive_level_q
  );
  dlms_link_model link_u (.mclk, .send, .rd, .bad, .win, .rx_valid, .rx_is_read,
    .rx_word, .rx_crc_err, .serial_clk);

  always #5 mclk = ~mclk;
  // 60 ns reference keeps twelve times its rate below the serial maximum
  always @(posedge mclk) begin
    ref_div <= (ref_div + 1) % 3;
    if (!ref_run) ref_clk <= 1'b0;
    else if (ref_div == 2) ref_clk <= ~ref_clk;
  end
  always @(posedge serial_clk) if (panel_wr_n_q === 1'b0 || panel_rd_n_q === 1'b0) n_sck++;
  always @(posedge mclk) begin
    if (fwd_lost_q === 1'b1) n_lost++;
    if (rd_valid_q === 1'b1) n_rdv++;
    if (fwd_valid_q === 1'b1 && exp_q.size() == 0) chk(1'b1, 1'b0);
    else if (fwd_valid_q === 1'b1) chk(fwd_word_q, exp_q.pop_front());
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge mclk);
  endtask : cy
  task automatic hw(input logic wr, input logic m_n, input logic s_n, input logic [17:0] d);
    host_cs_main_n <= m_n;
    host_cs_sub_n <= s_n;
    host_data <= d;
    host_cmd_data <= d[0];
    if (wr) host_wr_n <= 1'b0;
    else host_rd_n <= 1'b0;
    if (wr && !(m_n && s_n) && link_ready_q === 1'b1) exp_q.push_back({m_n, d[0], d});
    cy(4);
    {host_wr_n, host_rd_n, host_cs_main_n, host_cs_sub_n} <= 4'hF;
    cy(4);
  endtask : hw
  task automatic fr(input logic r, input logic b, input logic [19:0] wd);
    send <= 1'b1;
    rd <= r;
    bad <= b;
    win <= wd;
    cy(1);
    send <= 1'b0;
    n_sck = 0;
    cy(3);
  endtask : fr
  task automatic summarize;
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  initial begin
    #100000;
    n_fail++;
    summarize();
  end
  initial begin
    void'($urandom(32'hB4D0DB21));
    cy(2);
    chk(idle_w, 23'h7C0000);
    chk(link_fault_flag_q, 1'b0);
    cy(2);
    sys_rst <= 1'b0;
    cy(6);
    chk({is_master_q, test_mode_q}, 2'h2);
    for (k = 0; k < 4; k++) begin
      multiplier_select <= k[1:0];
      cy(8);
      chk(pll_enable_q, k != 3);
      if (k < 3) chk(pll_factor_q, 8 + 2 * k);
      if (k < 3) chk(bits_per_ref_q, 16 + 4 * k);
    end
    multiplier_select <= 2'h2;
    cy(8);
    chk(host_in_en_q, 1'b1);
    hw(1'b1, 1'b0, 1'b1, 18'($urandom));
    chk(n_lost, 1);
    pll_locked <= 1'b1;
    for (i = 0; i < 200 && link_ready_q !== 1'b1; i++) cy(1);
    chk(i > 40 && i < 60, 1'b1);
    for (k = 0; k < 3; k++) hw(1'b1, k != 0, k != 1, 18'($urandom));
    chk(exp_q.size(), 0);
    rd_crc_err <= 1'b1;
    cy(1);
    rd_crc_err <= 1'b0;
    cy(3);
    chk(link_fault_flag_q, 1'b1);
    hw(1'b0, 1'b0, 1'b1, 18'h00000);
    chk(link_fault_flag_q, 1'b0);
    rd_crc_err <= 1'b1;
    cy(1);
    rd_crc_err <= 1'b0;
    sleep_request_n <= 1'b0;
    cy(8);
    chk({pll_enable_q, host_in_en_q, link_ready_q, link_fault_flag_q}, 4'h0);
    sleep_request_n <= 1'b1;
    cy(8);
    chk(link_ready_q, 1'b0);
    for (i = 0; i < 200 && link_ready_q !== 1'b1; i++) cy(1);
    chk(i > 25 && i < 60, 1'b1);
    ref_run <= 1'b0;
    cy(90);
    chk(pll_enable_q, 1'b1);
    cy(25);
    chk({pll_enable_q, host_in_en_q}, 2'h0);
    role_select <= 1'b0;
    cy(10);
    chk({is_master_q, pll_enable_q, turnaround_en_q}, 3'h1);
    for (k = 0; k < 4; k++) begin
      {drive_strength_sel1, drive_strength_sel0} <= k[1:0];
      cy(5);
      chk({drive_level_q, data_soft_edge_q, strobe_soft_edge_q}, {k[1:0], ~k[0], 1'b0});
    end
    for (k = 0; k < 2; k++) begin
      w = {k[0], 19'($urandom)};
      fr(1'b0, 1'b0, w);
      chk(panel_wr_n_q, 1'b0);
      cy(300);
      chk(idle_w, {w[19], ~w[19], 2'h3, w[18:0]});
      chk(n_sck, WRL);
    end
    panel_data_in <= 18'($urandom);
    fr(1'b1, 1'b0, w);
    chk({panel_rd_n_q, panel_data_oe_q}, 2'h0);
    cy(300);
    chk({rd_data_q, panel_data_oe_q, n_sck[3:0]}, {panel_data_in, 1'b1, 4'(RDL)});
    chk(n_rdv, 1);
    store_only_select <= 1'b1;
    cy(5);
    fr(1'b1, 1'b0, w);
    chk({panel_rd_n_q, turnaround_en_q}, 2'h2);
    cy(300);
    chk(n_sck, 0);
    chk(n_rdv, 1);
    store_only_select <= 1'b0;
    fr(1'b0, 1'b1, w);
    cy(300);
    chk(link_fault_flag_q, 1'b1);
    sleep_request_n <= 1'b0;
    cy(6);
    chk({idle_w, link_fault_flag_q}, {23'h7C0000, 1'b0});
    sleep_request_n <= 1'b1;
    cy(6);
    fr(1'b0, 1'b0, 20'h8AAAA);
    cy(300);
    link_active <= 1'b0;
    cy(6);
    chk(idle_w, 23'h7C0000);
    summarize();
  end
endmodule : testbench
